// ===== bench/fast_timer_core_with_pll_clock_bench.sv
// self-checking bench for the fast timer core
// assumes ftc_pkg, ftc_timer and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module fast_timer_core_with_pll_clock_bench
  import ftc_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic fastClkTick = 1'b0;
  logic sysClkFromSynth = 1'b0;
  ftc_bus_req_t busReq = '0;
  logic [7:0] rdData;
  ftc_flags_t flags;
  ftc_clk_status_t clkStatus;
  logic [7:0] v;
  int badCount = 0;
  int checked = 0;
  int cycles = 0;

  always #4 mclk = ~mclk;

  ftc_timer #(.LOCK_CYCLES(20)) dut (.mclk(mclk), .arst_n(arst_n), .busReq(busReq), .fastClkTick(fastClkTick),
    .sysClkFromSynth(sysClkFromSynth), .rdData(rdData), .flags(flags), .clkStatus(clkStatus));

  // fast clock modelled as a tick every third cycle
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    fastClkTick <= (cycles % 3 == 0);
    if (cycles == 4000)
    begin
      badCount++;
      wrapUp();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic rd(input logic [7:0] a);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    #1 v = rdData;
  endtask

  // run the counter with a control value for a fixed span, then stop and read it
  task automatic run(input logic [7:0] ctl, input int n);
    wr(8'h2f, ctl);
    repeat (n) @(posedge mclk);
    wr(8'h2f, 8'h00);
    rd(8'h2e);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] al[7] = '{8'h29, 8'h2f, 8'h2e, 8'h2d, 8'h2c, 8'h2b, 8'h00};
    foreach (al[i])
    begin
      rd(al[i]);
      chk("reset", v, 8'h00);
    end
    wr(8'h2f, 8'hff);
    rd(8'h2f);
    chk("ctrl", v, 8'h8f);
    wr(8'h2f, 8'h00);
    wr(8'h2d, 8'ha5);
    rd(8'h2d);
    chk("cmpA", v, 8'ha5);
    wr(8'h2c, 8'h5a);
    rd(8'h2c);
    chk("cmpB", v, 8'h5a);
  endtask

  task automatic t_cntwr();
    wr(8'h38, 8'h07);
    cyc(1'b1, 1'b0, 8'h2e, 8'h5a);
    cyc(1'b0, 1'b1, 8'h2e, 8'h00);
    cyc(1'b0, 1'b1, 8'h2e, 8'h00);
    #1 chk("cntold", rdData, 8'h00);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk("cntwr", rdData, 8'h5a);
    repeat (3) @(posedge mclk);
    #1 chk("nomatch", flags.compareFlagB, 1'b0);
  endtask

  task automatic t_div();
    int e;
    for (int cs = 0; cs < 5; cs++)
    begin
      e = (cs == 0) ? 0 : 32 >> (cs - 1);
      wr(8'h2e, 8'h00);
      run(8'(8'h40 | cs), 30);
      chk("div", (v + 2 >= e && v <= e + 2), 8'h01);
    end
  endtask

  task automatic t_top();
    wr(8'h38, 8'h07);
    wr(8'h2b, 8'h05);
    wr(8'h2d, 8'h03);
    wr(8'h2e, 8'h00);
    run(8'h81, 20);
    chk("clr", v <= 8'h05, 8'h01);
    chk("ovf", flags.overflowFlag, 1'b1);
    chk("flagA", flags.compareFlagA, 1'b1);
    wr(8'h38, 8'h07);
    wr(8'h2e, 8'h00);
    run(8'h01, 20);
    chk("pass", v > 8'h08, 8'h01);
    chk("noovf", flags.overflowFlag, 1'b0);
    wr(8'h2e, 8'hfe);
    run(8'h01, 4);
    chk("wrap", flags.overflowFlag, 1'b1);
  endtask

  task automatic t_synth();
    wr(8'h29, 8'h04);
    rd(8'h29);
    chk("early", v, 8'h00);
    wr(8'h29, 8'h02);
    for (int i = 0; i < 20 && v[0] !== 1'b1; i++)
      rd(8'h29);
    chk("lock", v, 8'h03);
    chk("locked", clkStatus.synthLocked, 1'b1);
    chk("run", clkStatus.synthRun, 1'b1);
    chk("ref", clkStatus.refOscRun, 1'b1);
    wr(8'h29, 8'h06);
    rd(8'h29);
    chk("fast", v, 8'h07);
    chk("async", clkStatus.asyncMode, 1'b1);
    wr(8'h2e, 8'h77);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    rd(8'h2e);
    chk("awr", v, 8'h77);
    wr(8'h2e, 8'h00);
    run(8'h01, 30);
    chk("acnt", (v >= 8'h09 && v <= 8'h0d), 8'h01);
  endtask

  task automatic t_forced();
    @(posedge mclk);
    sysClkFromSynth <= 1'b1;
    wr(8'h29, 8'h00);
    rd(8'h29);
    chk("forced", v[1], 1'b1);
    @(posedge mclk);
    sysClkFromSynth <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_cntwr();
    t_div();
    t_top();
    t_synth();
    t_forced();
    wrapUp();
  end
endmodule
`default_nettype wire

// ===== bench/ftc_timer_props.sv
// port checker for the fast timer core
// assumes it is bound onto ftc_timer
`timescale 1ns/1ps
`default_nettype none
module ftc_timer_props
  import ftc_pkg::*;
#(
  parameter int LOCK_CYCLES = 20
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire ftc_bus_req_t busReq,
  input wire logic fastClkTick,
  input wire logic sysClkFromSynth,
  input wire logic [7:0] rdData,
  input wire ftc_flags_t flags,
  input wire ftc_clk_status_t clkStatus
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // cycles the synthesizer has been running, for the lock timing checks
  int runCnt_q;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      runCnt_q <= 0;
    end
    else
    begin
      runCnt_q <= clkStatus.synthRun ? runCnt_q + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  rd_idle_zero_a: assert property (!busReq.rd |=> rdData == 8'h00) else $error("read data not idle");
  unmapped_read_a: assert property (busReq.rd && busReq.addr == 8'h00 |=> rdData == 8'h00) else $error("unmapped read");
  csr_reserved_a: assert property (busReq.rd && busReq.addr == 8'h29 |=> rdData[7:3] == 5'h00)
    else $error("status reserved bits set");
  ctrl_reserved_a: assert property (busReq.rd && busReq.addr == 8'h2f |=> rdData[6:4] == 3'h0)
    else $error("control bits 6..4 set");
  async_synth_a: assert property (clkStatus.asyncMode |-> clkStatus.synthRun) else $error("async without synth");
  ref_osc_a: assert property (clkStatus.refOscRun |-> clkStatus.synthRun) else $error("oscillator without synth");
  forced_synth_a: assert property (sysClkFromSynth |=> clkStatus.synthRun) else $error("synth not forced on");
  lock_wait_a: assert property ($rose(clkStatus.synthRun) |-> !clkStatus.synthLocked [*8])
    else $error("lock too early");
  ovf_clear_a: assert property ($fell(flags.overflowFlag) |->
    $past(busReq.wr && busReq.addr == 8'h38 && busReq.wdata[2]))
    else $error("overflow flag lost");
  cmpa_clear_a: assert property ($fell(flags.compareFlagA) |->
    $past(busReq.wr && busReq.addr == 8'h38 && busReq.wdata[1]))
    else $error("compare flag lost");
  lock_min_time_a: assert property ($rose(clkStatus.synthLocked) |-> runCnt_q >= LOCK_CYCLES)
    else $error("lock before wait time");
  lock_max_time_a: assert property (clkStatus.synthRun && runCnt_q == LOCK_CYCLES + 8 |-> clkStatus.synthLocked)
    else $error("lock not reached");
  ovf_seen_c: cover property (flags.overflowFlag);
  async_seen_c: cover property (clkStatus.asyncMode);
  lock_seen_c: cover property ($rose(clkStatus.synthLocked));
endmodule
bind ftc_timer ftc_timer_props #(.LOCK_CYCLES(LOCK_CYCLES)) uProps (.mclk(mclk), .arst_n(arst_n), .busReq(busReq),
  .fastClkTick(fastClkTick), .sysClkFromSynth(sysClkFromSynth), .rdData(rdData), .flags(flags),
  .clkStatus(clkStatus));
`default_nettype wire

// ===== hdl/ftc_map.svh
// register offsets, field positions, reset values and timing counts of the fast timer core
// assumes an 8-bit register address and 8-bit register data
`ifndef FTC_MAP_SVH
`define FTC_MAP_SVH

// register offsets
`define FTC_ADDR_SYNTH_CSR 8'h29
`define FTC_ADDR_CTRL_B 8'h2f
`define FTC_ADDR_COUNT 8'h2e
`define FTC_ADDR_CMP_A 8'h2d
`define FTC_ADDR_CMP_B 8'h2c
`define FTC_ADDR_TOP 8'h2b
`define FTC_ADDR_FLAGS 8'h38

// timer_control_b fields
`define FTC_CTRLB_CLEAR_TOP 7
`define FTC_CTRLB_PRE_RESET 6
`define FTC_CTRLB_CS_HI 3
`define FTC_CTRLB_CS_LO 0

// synth_clock_control_status fields
`define FTC_CSR_FAST_EN 2
`define FTC_CSR_SYNTH_EN 1
`define FTC_CSR_LOCK 0

// flags register fields
`define FTC_FLAG_OVF 2
`define FTC_FLAG_CMP_A 1
`define FTC_FLAG_CMP_B 0

// reset values
`define FTC_RST_CTRL_B 8'h00
`define FTC_RST_COUNT 8'h00
`define FTC_RST_CMP 8'h00
`define FTC_RST_TOP 8'h00

// widths and timing
`define FTC_DATA_W 8
`define FTC_PRE_W 14
`define FTC_LOCK_CNT_W 16
`define FTC_COUNT_MAX 8'hff
`define FTC_CLK_MHZ 125
`define FTC_LOCK_TIME_US 100
`define FTC_LOCK_CYCLES (`FTC_LOCK_TIME_US * `FTC_CLK_MHZ)
`define FTC_WR_DELAY_SYNC 2'h0
`define FTC_WR_DELAY_ASYNC 2'h1

`endif

// ===== hdl/ftc_pkg.sv
// types of the fast timer core: register bus carrier, synthesizer state, module state
// assumes ftc_map.svh is on the include path
`include "ftc_map.svh"

package ftc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ftc_bus_req_t;

  typedef struct packed {
    logic compareFlagA;
    logic compareFlagB;
    logic overflowFlag;
  } ftc_flags_t;

  typedef struct packed {
    logic synthRun;
    logic refOscRun;
    logic asyncMode;
    logic synthLocked;
  } ftc_clk_status_t;

  typedef enum logic [1:0] {
    LK_OFF,
    LK_WAIT,
    LK_LOCKED
  } ftc_lock_st_t;

  typedef struct packed {
    logic clearOnTop;
    logic [3:0] clockSel;
    logic [`FTC_PRE_W-1:0] prescale;
    logic [7:0] count;
    logic [7:0] cmpA;
    logic [7:0] cmpB;
    logic [7:0] top;
    logic counted;
    logic wrPend;
    logic [1:0] wrDelay;
    logic [7:0] wrVal;
    logic [2:0] flagSet;
    ftc_flags_t flags;
    logic fastEn;
    logic synthEn;
    ftc_lock_st_t lockSt;
    logic [`FTC_LOCK_CNT_W-1:0] lockCnt;
    logic [7:0] rdData;
    ftc_clk_status_t clkStat;
  } ftc_state_t;

endpackage

// ===== hdl/ftc_timer.sv
// fast timer core: 8-bit up counter, prescaler, two compares, top compare, synth clock switch
// assumes a single-cycle register port and a synchronous one-cycle fast clock tick input
//
// Summary of operation
// - clear-on-top set: match clears counter next cycle
// - clear-on-top clear: counter runs past top
// - prescaler reset bit self-clears, reads zero
// - clock select 0 stops, else source/2^(code-1)
// - counter is 8-bit, read and write
// - count write lands 1 (sync)/2 (async) cycles
// - compares A and B are 8-bit read/write
// - only counting to value makes a match
// - compare match sets its flag after delay
// - top match with clear-on-top set clears counter, sets overflow flag
// - top register same in every mode
// - fast enable selects fast clock, else system
// - fast enable settable only with synth enabled or synth clocking system
// - synth enable starts synth, and reference oscillator unless synth clocks system
// - synth enable reads one when synth clocks system
// - lock indicator rises once synth locked
// - status bits 7..3 zero, bit 0 read-only
// - overflow flag on 0xff to 0 or top to 0
`timescale 1ns/1ps
`default_nettype none

module ftc_timer
  import ftc_pkg::*;
#(
  parameter int LOCK_CYCLES = `FTC_LOCK_CYCLES
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire ftc_bus_req_t busReq,
  input wire logic fastClkTick,
  input wire logic sysClkFromSynth,
  output logic [7:0] rdData,
  output ftc_flags_t flags,
  output ftc_clk_status_t clkStatus
);

  localparam logic [`FTC_LOCK_CNT_W-1:0] LOCK_LAST = `FTC_LOCK_CNT_W'(LOCK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rstMeta_q;
  logic rstSync_n;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state

  ftc_state_t st_q;
  ftc_state_t st_d;

  logic wrCtrlB;
  logic wrCount;
  logic wrCsr;
  logic wrFlags;
  logic srcTick;
  logic preTick;
  logic [`FTC_PRE_W:0] preMask;
  logic matchA;
  logic matchB;
  logic matchTop;
  logic topClear;
  logic newSynthEn;
  logic synthEnRead;

  always_comb
  begin
    st_d = st_q;
    preMask = '0;

    wrCtrlB = busReq.wr && (busReq.addr == `FTC_ADDR_CTRL_B);
    wrCount = busReq.wr && (busReq.addr == `FTC_ADDR_COUNT);
    wrCsr = busReq.wr && (busReq.addr == `FTC_ADDR_SYNTH_CSR);
    wrFlags = busReq.wr && (busReq.addr == `FTC_ADDR_FLAGS);

    // source of the prescaler: fast tick in async mode, every cycle otherwise
    srcTick = st_q.fastEn ? fastClkTick : 1'b1;

    // tick when the low (code-1) prescaler bits are all ones
    if (st_q.clockSel != 4'h0)
    begin
      preMask = (`FTC_PRE_W+1)'((`FTC_PRE_W+1)'(1) << (st_q.clockSel - 4'h1)) - (`FTC_PRE_W+1)'(1);
    end
    preTick = srcTick && (st_q.clockSel != 4'h0) &&
              ((st_q.prescale & preMask[`FTC_PRE_W-1:0]) == preMask[`FTC_PRE_W-1:0]);

    // a match exists only in the cycle after the counter counted onto the value
    matchA = st_q.counted && (st_q.count == st_q.cmpA);
    matchB = st_q.counted && (st_q.count == st_q.cmpB);
    matchTop = st_q.counted && (st_q.count == st_q.top);
    // clear lands on the edge closing the match cycle, so the count goes top to zero
    topClear = matchTop && st_q.clearOnTop;

    //////////////////////////////////////////////////////////////////////////////
    // prescaler

    if (wrCtrlB && busReq.wdata[`FTC_CTRLB_PRE_RESET])
    begin
      st_d.prescale = '0;
    end
    else if (st_q.clockSel == 4'h0)
    begin
      st_d.prescale = '0;
    end
    else if (srcTick)
    begin
      st_d.prescale = st_q.prescale + `FTC_PRE_W'(1);
    end

    //////////////////////////////////////////////////////////////////////////////
    // counter

    st_d.counted = 1'b0;
    st_d.flagSet = 3'b000;

    if (st_q.wrPend)
    begin
      if (st_q.wrDelay == 2'h0)
      begin
        st_d.wrPend = 1'b0;
        st_d.count = st_q.wrVal;
      end
      else
      begin
        st_d.wrDelay = st_q.wrDelay - 2'h1;
      end
    end

    if (st_q.wrPend && (st_q.wrDelay == 2'h0))
    begin
      st_d.counted = 1'b0;
    end
    else if (topClear)
    begin
      st_d.count = 8'h00;
      st_d.flagSet[`FTC_FLAG_OVF] = 1'b1;
    end
    else if (preTick)
    begin
      st_d.count = st_q.count + 8'h01;
      st_d.counted = 1'b1;
      if (st_q.count == `FTC_COUNT_MAX)
      begin
        st_d.flagSet[`FTC_FLAG_OVF] = 1'b1;
      end
    end

    if (wrCount)
    begin
      st_d.wrPend = 1'b1;
      st_d.wrVal = busReq.wdata;
      st_d.wrDelay = st_q.fastEn ? `FTC_WR_DELAY_ASYNC : `FTC_WR_DELAY_SYNC;
    end

    if (matchA)
    begin
      st_d.flagSet[`FTC_FLAG_CMP_A] = 1'b1;
    end
    if (matchB)
    begin
      st_d.flagSet[`FTC_FLAG_CMP_B] = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////////
    // flags: write one clears, a set in the same cycle wins

    if (wrFlags)
    begin
      if (busReq.wdata[`FTC_FLAG_OVF])
      begin
        st_d.flags.overflowFlag = 1'b0;
      end
      if (busReq.wdata[`FTC_FLAG_CMP_A])
      begin
        st_d.flags.compareFlagA = 1'b0;
      end
      if (busReq.wdata[`FTC_FLAG_CMP_B])
      begin
        st_d.flags.compareFlagB = 1'b0;
      end
    end
    if (st_q.flagSet[`FTC_FLAG_OVF])
    begin
      st_d.flags.overflowFlag = 1'b1;
    end
    if (st_q.flagSet[`FTC_FLAG_CMP_A])
    begin
      st_d.flags.compareFlagA = 1'b1;
    end
    if (st_q.flagSet[`FTC_FLAG_CMP_B])
    begin
      st_d.flags.compareFlagB = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////////
    // control and compare registers

    if (wrCtrlB)
    begin
      st_d.clearOnTop = busReq.wdata[`FTC_CTRLB_CLEAR_TOP];
      st_d.clockSel = busReq.wdata[`FTC_CTRLB_CS_HI:`FTC_CTRLB_CS_LO];
    end
    if (busReq.wr && (busReq.addr == `FTC_ADDR_CMP_A))
    begin
      st_d.cmpA = busReq.wdata;
    end
    if (busReq.wr && (busReq.addr == `FTC_ADDR_CMP_B))
    begin
      st_d.cmpB = busReq.wdata;
    end
    if (busReq.wr && (busReq.addr == `FTC_ADDR_TOP))
    begin
      st_d.top = busReq.wdata;
    end

    //////////////////////////////////////////////////////////////////////////////
    // synthesizer control and lock

    newSynthEn = wrCsr ? busReq.wdata[`FTC_CSR_SYNTH_EN] : st_q.synthEn;
    st_d.synthEn = newSynthEn;
    synthEnRead = st_q.synthEn || sysClkFromSynth;

    if (wrCsr)
    begin
      st_d.fastEn = busReq.wdata[`FTC_CSR_FAST_EN] && (newSynthEn || sysClkFromSynth);
    end
    else if (!synthEnRead)
    begin
      st_d.fastEn = 1'b0;
    end

    unique case (st_q.lockSt)
      LK_OFF:
      begin
        st_d.lockCnt = '0;
        if (synthEnRead)
        begin
          st_d.lockSt = LK_WAIT;
        end
      end
      LK_WAIT:
      begin
        if (!synthEnRead)
        begin
          st_d.lockSt = LK_OFF;
        end
        else if (st_q.lockCnt >= LOCK_LAST)
        begin
          st_d.lockSt = LK_LOCKED;
        end
        else
        begin
          st_d.lockCnt = st_q.lockCnt + `FTC_LOCK_CNT_W'(1);
        end
      end
      LK_LOCKED:
      begin
        if (!synthEnRead)
        begin
          st_d.lockSt = LK_OFF;
        end
      end
    endcase

    st_d.clkStat.synthRun = newSynthEn || sysClkFromSynth;
    st_d.clkStat.refOscRun = newSynthEn && !sysClkFromSynth;
    st_d.clkStat.asyncMode = st_d.fastEn;
    st_d.clkStat.synthLocked = (st_q.lockSt == LK_LOCKED);

    //////////////////////////////////////////////////////////////////////////////
    // read port, data in the cycle after the strobe

    st_d.rdData = 8'h00;
    if (busReq.rd)
    begin
      unique case (busReq.addr)
        `FTC_ADDR_CTRL_B:
        begin
          st_d.rdData = {st_q.clearOnTop, 1'b0, 2'b00, st_q.clockSel};
        end
        `FTC_ADDR_COUNT:
        begin
          st_d.rdData = st_q.count;
        end
        `FTC_ADDR_CMP_A:
        begin
          st_d.rdData = st_q.cmpA;
        end
        `FTC_ADDR_CMP_B:
        begin
          st_d.rdData = st_q.cmpB;
        end
        `FTC_ADDR_TOP:
        begin
          st_d.rdData = st_q.top;
        end
        `FTC_ADDR_SYNTH_CSR:
        begin
          st_d.rdData = {5'b00000, st_q.fastEn, synthEnRead, st_q.lockSt == LK_LOCKED};
        end
        `FTC_ADDR_FLAGS:
        begin
          st_d.rdData = {5'b00000, st_q.flags.overflowFlag, st_q.flags.compareFlagA, st_q.flags.compareFlagB};
        end
        default:
        begin
          st_d.rdData = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      st_q <= '{
        clearOnTop: 1'b0,
        clockSel: 4'h0,
        prescale: '0,
        count: `FTC_RST_COUNT,
        cmpA: `FTC_RST_CMP,
        cmpB: `FTC_RST_CMP,
        top: `FTC_RST_TOP,
        counted: 1'b0,
        wrPend: 1'b0,
        wrDelay: 2'h0,
        wrVal: 8'h00,
        flagSet: 3'b000,
        flags: '0,
        fastEn: 1'b0,
        synthEn: 1'b0,
        lockSt: LK_OFF,
        lockCnt: '0,
        rdData: 8'h00,
        clkStat: '0
      };
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rdData;
  assign flags = st_q.flags;
  assign clkStatus = st_q.clkStat;

endmodule

`default_nettype wire
